/* File: hdl/tscp_pkg.sv */
// Purpose: Shared constants, types and state records of the transmitter state control block
// Assumes: REF_CLK at 10 MHz; all cycle counts are derived from that rate below
// Notes:   Overview of operation follows as one line per item
// Overview of operation
// - A sixty-four bit one-time fuse image is the non-volatile configuration source.
// - Programmed fuse: copy fuse into registers, wait a delay, then deep sleep.
// - Unprogrammed fuse: skip the copy, wait, sleep, keep register initial values.
// - Serially written configuration is lost at reset; registers return to initial values.
// - Deep sleep goes to transmit on data pin high or clock pin falling.
// - Data falling after transmit gives standby; timer expiry returns to deep sleep.
// - Delay field all ones: never sleep from standby; data rise restarts transmit.
// - Clock line low longer than 16 us enters serial configuration mode.
// - Serial mode exits only after a STOP then clock low longer than 16 us.
// - Only single and multi byte writes and reads are supported.
// - The device answers only target address 21h after START or repeated START.
// - Direction bit zero means write, one means read.
// - An eight-bit register address follows the target address.
// - Acknowledge is a driven low; not-acknowledge is the line left high.
// - Eight eight-bit registers sit at register addresses 00h to 07h.
// - Initial values give amplitude keying, 433.92 MHz, 10 dBm, 32 ms delay.
// - Amplitude keying ramps amplifier level gradually at each keying edge.
// - Standby time is 2 ms times the delay field plus two.
// - Register seven bit seven is read-only and shows the fuse-programmed flag.
package tscp_pkg;

  // Register file shape
  localparam int TSCP_NUM_REGS = 8;
  localparam logic [6:0] TSCP_DEV_ADDR = 7'h21;
  localparam logic [2:0] TSCP_LAST_REG = 3'h7;
  localparam logic [2:0] TSCP_DLY_REG = 3'h1;
  localparam logic [2:0] TSCP_MOD_REG = 3'h3;
  localparam logic [2:0] TSCP_FLAG_REG = 3'h7;
  localparam int TSCP_FLAG_BIT = 7;
  localparam int TSCP_FSK_BIT = 7;
  localparam int TSCP_DLY_LSB = 4;
  localparam logic [3:0] TSCP_DLY_INFINITE = 4'hF;
  localparam logic [4:0] TSCP_DLY_OFFSET = 5'h02;
  localparam logic [7:0] TSCP_REG0_INIT = 8'hA0;
  localparam logic [7:0] TSCP_REG1_INIT = 8'hE1;
  localparam logic [7:0] TSCP_REG2_INIT = 8'h66;
  localparam logic [7:0] TSCP_REG3_INIT = 8'h48;
  localparam logic [7:0] TSCP_REG4_INIT = 8'h59;
  localparam logic [7:0] TSCP_REG5_INIT = 8'h70;
  localparam logic [7:0] TSCP_REG6_INIT = 8'h3D;
  localparam logic [7:0] TSCP_REG7_INIT = 8'h4B;
  localparam logic [63:0] TSCP_REG_INIT = {TSCP_REG7_INIT, TSCP_REG6_INIT, TSCP_REG5_INIT,
    TSCP_REG4_INIT, TSCP_REG3_INIT, TSCP_REG2_INIT, TSCP_REG1_INIT, TSCP_REG0_INIT};
  localparam logic [3:0] TSCP_BYTE_BITS = 4'h8;

  // Timing, figures in their own units and derived cycle counts
  localparam int TSCP_REF_CLK_MHZ = 10;
  localparam int TSCP_ENTRY_TIME_NS = 16000;
  localparam int TSCP_ENTRY_CYCLES = (TSCP_ENTRY_TIME_NS * TSCP_REF_CLK_MHZ + 999) / 1000;
  localparam int TSCP_TICK_TIME_US = 2000;
  localparam int TSCP_TICK_CYCLES = TSCP_TICK_TIME_US * TSCP_REF_CLK_MHZ;
  localparam int TSCP_POR_DELAY_US = 1000;
  localparam int TSCP_POR_DELAY_CYCLES = TSCP_POR_DELAY_US * TSCP_REF_CLK_MHZ;
  localparam int TSCP_RAMP_STEP_NS = 1000;
  localparam int TSCP_RAMP_CYCLES = (TSCP_RAMP_STEP_NS * TSCP_REF_CLK_MHZ) / 1000;
  localparam logic [3:0] TSCP_PA_MAX = 4'hF;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    TSCP_M_POWER  = 5'b00001,
    TSCP_M_SLEEP  = 5'b00010,
    TSCP_M_TX     = 5'b00100,
    TSCP_M_STBY   = 5'b01000,
    TSCP_M_SERIAL = 5'b10000
  } tscp_mode_t;

  // Serial transaction phases, one-hot
  typedef enum logic [5:0] {
    TSCP_I_IDLE  = 6'b000001,
    TSCP_I_ADDR  = 6'b000010,
    TSCP_I_REG   = 6'b000100,
    TSCP_I_WDATA = 6'b001000,
    TSCP_I_RDATA = 6'b010000,
    TSCP_I_SKIP  = 6'b100000
  } tscp_iphase_t;

  // Complete reference-domain state of the block
  typedef struct packed {
    logic [2:0] s_scl;
    logic [2:0] s_sda;
    logic [2:0] s_din;
    logic scl_f;
    logic sda_f;
    logic din_f;
    tscp_mode_t mode;
    tscp_iphase_t iph;
    logic [3:0] bitc;
    logic ack_ph;
    logic rd_first;
    logic mack;
    logic stop_seen;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [7:0] lowc;
    logic [15:0] cnt;
    logic [4:0] units;
    logic copy_on;
    logic [2:0] cidx;
    logic [3:0] pa;
    logic [7:0] rampc;
    logic sda_o;
    logic sda_oe;
    logic [7:0][7:0] regs;
  } tscp_state_t;

endpackage

/* File: hdl/tscp_top.sv */
// Purpose: Power-on sequencing, sleep/transmit/standby control and serial register port
// Assumes: LINK_SCL is both the serial clock and the transmit clock pin; SDA is open drain
// Notes:   The link domain only shifts in SDA bits; all decisions run on REF_CLK
`timescale 1ns/10ps
`default_nettype none
module tscp_top
  import tscp_pkg::*;
#(
  parameter logic [63:0] FUSE_IMAGE = TSCP_REG_INIT,             // Fuse contents, byte n at bits 8n
  parameter logic FUSE_PROGRAMMED = 1'b0,                        // Fuse has been programmed
  parameter logic [15:0] POR_DELAY_CYCLES = TSCP_POR_DELAY_CYCLES[15:0], // Wait before sleep
  parameter logic [15:0] TICK_CYCLES = TSCP_TICK_CYCLES[15:0]    // One 2 ms standby unit
) (
  input wire logic REF_CLK,          // Reference clock
  input wire logic RESET,            // Synchronous power-on reset, active high
  input wire logic LINK_SCL,         // Serial clock pin, also the transmit clock pin
  input wire logic SDA_IN,           // Serial data pin level
  input wire logic DIN,              // Transmit data pin
  output logic SDA_OUT,              // Serial data drive value
  output logic SDA_OE,               // Serial data drive enable
  output logic SLEEP_MODE,           // Deep sleep active
  output logic TX_ACTIVE,            // Transmitting
  output logic STANDBY_MODE,         // Standby active; its timer runs unless the delay field is all ones
  output logic SERIAL_MODE,          // Serial configuration mode
  output logic [3:0] PA_LEVEL,       // Amplifier drive level
  output logic [63:0] CFG_REGS       // Configuration registers, register n at bits 8n
);

  tscp_state_t q;
  tscp_state_t d;
  logic [7:0] rx_q;
  logic scl_new;
  logic sda_new;
  logic din_new;
  logic scl_rise;
  logic scl_fall;
  logic din_rise;
  logic din_fall;
  logic start_ev;
  logic stop_ev;
  logic long_low;
  logic [3:0] dly_field;
  logic pa_target;
  logic [7:0] rd_ptr;

  // Register read; unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input logic [7:0][7:0] regs, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx <= {5'h00, TSCP_LAST_REG}) begin
      v = regs[idx[2:0]];
    end
    return v;
  endfunction

  // Register write that keeps the fuse flag out of reach of the serial port
  function automatic logic [7:0] reg_merge(input logic [2:0] idx, input logic [7:0] old,
                                           input logic [7:0] val);
    logic [7:0] v;
    v = val;
    if (idx == TSCP_FLAG_REG) begin
      v[TSCP_FLAG_BIT] = old[TSCP_FLAG_BIT];
    end
    return v;
  endfunction

  // Link domain: capture one SDA bit per rising serial clock. The reference side reads
  // rx_q only after it has seen the eighth rise settle, and the next rise is at least one
  // serial clock period away, so the byte is stable when it is taken.
  always_ff @(posedge LINK_SCL) begin
    rx_q <= {rx_q[6:0], SDA_IN};
  end

  // Filtered pin levels: a change counts once the second and third stages agree
  always_comb begin
    scl_new = (q.s_scl[2] == q.s_scl[1]) ? q.s_scl[2] : q.scl_f;
    sda_new = (q.s_sda[2] == q.s_sda[1]) ? q.s_sda[2] : q.sda_f;
    din_new = (q.s_din[2] == q.s_din[1]) ? q.s_din[2] : q.din_f;
  end

  // Pin events seen on the filtered levels
  assign scl_rise = !q.scl_f && scl_new;
  assign scl_fall = q.scl_f && !scl_new;
  assign din_rise = !q.din_f && din_new;
  assign din_fall = q.din_f && !din_new;
  assign start_ev = q.scl_f && scl_new && q.sda_f && !sda_new;
  assign stop_ev = q.scl_f && scl_new && !q.sda_f && sda_new;
  // Fires once, on the first low sample beyond the 16 us window
  assign long_low = !scl_new && (q.lowc == TSCP_ENTRY_CYCLES[7:0]);
  assign dly_field = q.regs[TSCP_DLY_REG][TSCP_DLY_LSB +: 4];
  assign pa_target = q.mode[2] && (q.regs[TSCP_MOD_REG][TSCP_FSK_BIT] || q.din_f);
  assign rd_ptr = q.rd_first ? q.ptr : q.ptr + 8'h01;

  // Next state of the whole reference domain
  always_comb begin
    d = q;
    d.s_scl = {q.s_scl[1:0], LINK_SCL};
    d.s_sda = {q.s_sda[1:0], SDA_IN};
    d.s_din = {q.s_din[1:0], DIN};
    d.scl_f = scl_new;
    d.sda_f = sda_new;
    d.din_f = din_new;

    // Consecutive low samples of the clock line, saturating just past the window
    if (scl_new) begin
      d.lowc = 8'h00;
    end else if (q.lowc <= TSCP_ENTRY_CYCLES[7:0]) begin
      d.lowc = q.lowc + 8'h01;
    end

    // Mode sequencing
    case (q.mode)
      TSCP_M_POWER: begin
        if (q.copy_on) begin
          d.regs[q.cidx] = FUSE_IMAGE[{q.cidx, 3'h0} +: 8];
          d.cidx = q.cidx + 3'h1;
          if (q.cidx == TSCP_LAST_REG) begin
            d.copy_on = 1'b0;
            d.regs[TSCP_FLAG_REG][TSCP_FLAG_BIT] = 1'b1;
          end
        end else if (q.cnt == POR_DELAY_CYCLES - 16'h0001) begin
          d.cnt = 16'h0000;
          d.mode = TSCP_M_SLEEP;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      TSCP_M_SLEEP: begin
        if (long_low) begin
          d.mode = TSCP_M_SERIAL;
        end else if (din_new || scl_fall) begin
          d.mode = TSCP_M_TX;
        end
      end
      TSCP_M_TX: begin
        if (long_low) begin
          d.mode = TSCP_M_SERIAL;
        end else if (din_fall) begin
          d.mode = TSCP_M_STBY;
          d.cnt = 16'h0000;
          d.units = 5'h00;
        end
      end
      TSCP_M_STBY: begin
        if (long_low) begin
          d.mode = TSCP_M_SERIAL;
        end else if (din_rise) begin
          d.mode = TSCP_M_TX;
        end else if (dly_field != TSCP_DLY_INFINITE) begin
          // Whole-unit timer: the period is counted in 2 ms units
          if (q.cnt == TICK_CYCLES - 16'h0001) begin
            d.cnt = 16'h0000;
            d.units = q.units + 5'h01;
            if (q.units + 5'h01 == {1'b0, dly_field} + TSCP_DLY_OFFSET) begin
              d.mode = TSCP_M_SLEEP;
            end
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end
      end
      TSCP_M_SERIAL: begin
        if (stop_ev) begin
          d.stop_seen = 1'b1;
        end else if (start_ev) begin
          d.stop_seen = 1'b0;
        end
        if (long_low && q.stop_seen) begin
          d.mode = TSCP_M_SLEEP;
          d.stop_seen = 1'b0;
        end
      end
      default: begin
        d.mode = TSCP_M_SLEEP;
      end
    endcase

    // Serial engine; it ignores the bus outside serial mode
    if (!q.mode[4]) begin
      d.iph = TSCP_I_IDLE;
      d.sda_oe = 1'b0;
      d.ack_ph = 1'b0;
      d.bitc = 4'h0;
    end else if (start_ev) begin
      // START and repeated START both begin a new address phase
      d.iph = TSCP_I_ADDR;
      d.bitc = 4'h0;
      d.ack_ph = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      d.iph = TSCP_I_IDLE;
      d.bitc = 4'h0;
      d.ack_ph = 1'b0;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.ack_ph) begin
        d.mack = sda_new; // Host answer after a read byte
      end else if (q.bitc < TSCP_BYTE_BITS) begin
        d.bitc = q.bitc + 4'h1;
      end
    end else if (scl_fall) begin
      if (q.ack_ph) begin
        // End of the acknowledge slot
        d.ack_ph = 1'b0;
        d.bitc = 4'h0;
        d.sda_oe = 1'b0;
        if (q.iph == TSCP_I_RDATA) begin
          if (q.mack) begin
            d.iph = TSCP_I_SKIP;
          end else begin
            d.ptr = rd_ptr;
            d.rd_first = 1'b0;
            d.tx = reg_read(q.regs, rd_ptr);
            d.sda_oe = !d.tx[7];
          end
        end
      end else if (q.bitc == TSCP_BYTE_BITS) begin
        // Byte complete: decide and drive the acknowledge
        d.ack_ph = 1'b1;
        d.sda_oe = 1'b0;
        case (q.iph)
          TSCP_I_ADDR: begin
            if (rx_q[7:1] == TSCP_DEV_ADDR) begin
              d.sda_oe = 1'b1;
              d.rd_first = 1'b1;
              d.iph = rx_q[0] ? TSCP_I_RDATA : TSCP_I_REG;
            end else begin
              d.iph = TSCP_I_SKIP;
            end
          end
          TSCP_I_REG: begin
            d.ptr = rx_q;
            d.iph = TSCP_I_WDATA;
            d.sda_oe = 1'b1;
          end
          TSCP_I_WDATA: begin
            // Unmapped addresses are not acknowledged and store nothing
            if (q.ptr <= {5'h00, TSCP_LAST_REG}) begin
              d.regs[q.ptr[2:0]] = reg_merge(q.ptr[2:0], q.regs[q.ptr[2:0]], rx_q);
              d.sda_oe = 1'b1;
            end
            d.ptr = q.ptr + 8'h01;
          end
          TSCP_I_RDATA: begin
            d.mack = 1'b1; // Host must pull low to ask for more
          end
          default: begin
            d.ack_ph = 1'b0;
          end
        endcase
        if (q.iph == TSCP_I_IDLE || q.iph == TSCP_I_SKIP) begin
          d.bitc = 4'h0;
        end
      end else if (q.iph == TSCP_I_RDATA && q.bitc != 4'h0) begin
        // Next read bit, MSB first; a one is sent by releasing the line
        d.tx = {q.tx[6:0], 1'b0};
        d.sda_oe = !q.tx[6];
      end
    end
    d.sda_o = 1'b0;

    // Amplifier ramp: step the level one notch per ramp interval toward its target
    if (q.rampc == TSCP_RAMP_CYCLES[7:0] - 8'h01) begin
      d.rampc = 8'h00;
      if (pa_target && q.pa != TSCP_PA_MAX) begin
        d.pa = q.pa + 4'h1;
      end else if (!pa_target && q.pa != 4'h0) begin
        d.pa = q.pa - 4'h1;
      end
    end else begin
      d.rampc = q.rampc + 8'h01;
    end

    // Power-on reset: volatile registers back to initial values
    if (RESET) begin
      d = '0;
      d.s_scl = 3'h7;
      d.s_sda = 3'h7;
      d.scl_f = 1'b1;
      d.sda_f = 1'b1;
      d.mode = TSCP_M_POWER;
      d.iph = TSCP_I_IDLE;
      d.regs = TSCP_REG_INIT;
      d.copy_on = FUSE_PROGRAMMED;
    end
  end

  // Reference domain state register
  always_ff @(posedge REF_CLK) begin
    q <= d;
  end

  // Outputs straight from state flip-flops
  assign SDA_OUT = q.sda_o;
  assign SDA_OE = q.sda_oe;
  assign SLEEP_MODE = q.mode[1];
  assign TX_ACTIVE = q.mode[2];
  assign STANDBY_MODE = q.mode[3];
  assign SERIAL_MODE = q.mode[4];
  assign PA_LEVEL = q.pa;
  assign CFG_REGS = q.regs;

endmodule // tscp_top
`default_nettype wire

/* File: verif/tscp_top_chk.sv */
// Purpose: Pin-level checks of the transmitter control block
// Assumes: One clock domain at the top ports
// Notes:   Clock-low and standby spans are counted in helper logic
`timescale 1ns/10ps
`default_nettype none
module tscp_top_chk
  import tscp_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'h000A // Standby unit
) (
  input wire logic REF_CLK, // Reference clock
  input wire logic RESET, // Synchronous reset
  input wire logic LINK_SCL, // Serial clock pin
  input wire logic SDA_OE, // Data pull enable
  input wire logic SLEEP_MODE, // Deep sleep
  input wire logic TX_ACTIVE, // Transmitting
  input wire logic STANDBY_MODE, // Standby
  input wire logic SERIAL_MODE, // Serial mode
  input wire logic [3:0] PA_LEVEL, // Amplifier level
  input wire logic [63:0] CFG_REGS // Registers
);
  logic [8:0] low_q;
  logic [19:0] stby_q;
  logic [19:0] span;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Saturating, so a long idle low cannot wrap into a short count
  always_ff @(posedge REF_CLK) begin
    low_q <= (RESET || LINK_SCL) ? 9'h000 : low_q + {8'h00, low_q != 9'h1FF};
    stby_q <= (RESET || !STANDBY_MODE) ? 20'h00000 : stby_q + 20'h00001;
  end
  // Expected standby length from the delay field
  assign span = ({16'h0000, CFG_REGS[15:12]} + 20'h00002) * {4'h0, TICK_CYCLES};
  drive_serial_a: assert property (SDA_OE |-> SERIAL_MODE)
    else $error("data pulled outside serial mode");
  tx_cause_a: assert property ($rose(TX_ACTIVE) |-> $past(SLEEP_MODE || STANDBY_MODE))
    else $error("transmit from wrong mode");
  stby_cause_a: assert property ($rose(STANDBY_MODE) |-> $past(TX_ACTIVE))
    else $error("standby not after transmit");
  stby_span_a: assert property ($fell(STANDBY_MODE) && SLEEP_MODE |->
    stby_q + 20'h00002 >= span && stby_q <= span + 20'h00002)
    else $error("standby time wrong");
  never_sleep_a: assert property (STANDBY_MODE &&
    CFG_REGS[15:12] == TSCP_DLY_INFINITE |=> !SLEEP_MODE)
    else $error("slept with endless delay");
  flag_hold_a: assert property (SERIAL_MODE |=> $stable(CFG_REGS[63]))
    else $error("fuse flag written");
  cfg_quiet_a: assert property (SLEEP_MODE || TX_ACTIVE || STANDBY_MODE |->
    $stable(CFG_REGS))
    else $error("registers changed outside serial mode");
  pa_step_a: assert property ($changed(PA_LEVEL) |->
    5'(PA_LEVEL) - 5'($past(PA_LEVEL)) inside {5'h01, 5'h1F})
    else $error("amplifier level jumped");
  entry_low_a: assert property ($rose(SERIAL_MODE) |-> low_q >= 9'h0A1)
    else $error("serial entry too early");
  exit_low_a: assert property ($fell(SERIAL_MODE) |-> low_q >= 9'h0A1)
    else $error("serial exit too early");
  cover property ($rose(SERIAL_MODE));
  cover property (SDA_OE);
  cover property ($fell(STANDBY_MODE) && SLEEP_MODE);
endmodule // tscp_top_chk
bind tscp_top tscp_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.REF_CLK(REF_CLK),
  .RESET(RESET), .LINK_SCL(LINK_SCL), .SDA_OE(SDA_OE), .SLEEP_MODE(SLEEP_MODE),
  .TX_ACTIVE(TX_ACTIVE), .STANDBY_MODE(STANDBY_MODE), .SERIAL_MODE(SERIAL_MODE),
  .PA_LEVEL(PA_LEVEL), .CFG_REGS(CFG_REGS));
`default_nettype wire

/* File: verif/tscp_host.sv */
// Purpose: Host controller model on the serial, clock and data pins
// Assumes: Pins move on the REF_CLK falling edge
// Notes:   Bit time is 20 reference cycles, well above the filter delay
`timescale 1ns/10ps
`default_nettype none
module tscp_host
  import tscp_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic sda_in, // Resolved data wire
  output var logic scl_o, // Serial clock pin
  output var logic sda_o, // Data drive, high releases
  output var logic din_o // Transmit data pin
);
  // Idle: both serial lines released high, transmit data pin low
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // START is (1,0), STOP is (0,1); the second data level moves with the clock high
  task automatic cond(input logic first, input logic last);
    step(5);
    sda_o = first;
    step(5);
    scl_o = 1'b1;
    step(10);
    sda_o = last;
    step(10);
    scl_o = last;
  endtask
  // Byte MSB first, then the answer bit; q holds what the wire showed
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
      output logic ack);
    for (int i = 8; i >= 0; i--) begin
      step(5);
      sda_o = (i == 0) ? last : d[i - 1];
      step(5);
      scl_o = 1'b1;
      step(10);
      if (i == 0) begin
        ack = sda_in;
      end else begin
        q[i - 1] = sda_in;
      end
      scl_o = 1'b0;
    end
  endtask
  // Long clock-low hold, used to enter and to leave serial mode
  task automatic scl_low(input int n);
    scl_o = 1'b0;
    step(n);
    scl_o = 1'b1;
    step(5);
  endtask
  task automatic set_din(input logic v);
    step(1);
    din_o = v;
  endtask
endmodule // tscp_host
`default_nettype wire

/* File: verif/tscp_top_tb.sv */
// Purpose: Self-checking bench for the transmitter control block
// Assumes: Short power-on and standby counts set through parameters
// Notes:   A second instance with a programmed fuse checks the power-on copy
`timescale 1ns/10ps
`default_nettype none
module tscp_top_tb
  import tscp_pkg::*;
;
  localparam logic [63:0] FUSE_DATA = 64'h0123456789ABCDEF; // Arbitrary image
  logic ref_clk;
  logic reset;
  logic [15:0] rdata;
  int fails;
  int num_checks;
  wire logic scl;
  wire logic sda_drv;
  wire logic din;
  wire logic sda_oe;
  wire logic sda_w;
  wire logic [3:0] modes;
  wire logic [3:0] pa;
  wire logic [63:0] cfg;
  wire logic [63:0] fuse_cfg;
  wire logic [3:0] fuse_modes;
  wire logic [3:0] fuse_pa;
  wire logic fuse_oe;
  wire logic fuse_out;
  wire logic sda_out;
  // Open-drain wire with pull-up
  assign sda_w = sda_drv & ~sda_oe;
  tscp_top #(.POR_DELAY_CYCLES(16'h0014), .TICK_CYCLES(16'h000A)) u_dut (
    .REF_CLK(ref_clk), .RESET(reset), .LINK_SCL(scl), .SDA_IN(sda_w), .DIN(din),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SLEEP_MODE(modes[0]), .TX_ACTIVE(modes[1]),
    .STANDBY_MODE(modes[2]), .SERIAL_MODE(modes[3]), .PA_LEVEL(pa), .CFG_REGS(cfg));
  tscp_top #(.FUSE_IMAGE(FUSE_DATA), .FUSE_PROGRAMMED(1'b1), .POR_DELAY_CYCLES(16'h0014),
    .TICK_CYCLES(16'h000A)) u_fuse (.REF_CLK(ref_clk), .RESET(reset), .LINK_SCL(scl),
    .SDA_IN(1'b1), .DIN(din), .SDA_OUT(fuse_out), .SDA_OE(fuse_oe),
    .SLEEP_MODE(fuse_modes[0]), .TX_ACTIVE(fuse_modes[1]), .STANDBY_MODE(fuse_modes[2]),
    .SERIAL_MODE(fuse_modes[3]), .PA_LEVEL(fuse_pa), .CFG_REGS(fuse_cfg));
  tscp_host u_host (.ref_clk(ref_clk), .sda_in(sda_w), .scl_o(scl), .sda_o(sda_drv),
    .din_o(din));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bound covers filter delay and the longest timer used here
  task automatic wait_mode(input logic [3:0] m);
    for (int i = 0; i < 400 && modes !== m; i++) begin
      @(negedge ref_clk);
    end
    check(modes, m);
  endtask
  // Register address, nw bytes written, then nr bytes read after a repeated START
  task automatic frame(input logic [7:0] dev, input logic [7:0] a, input logic [15:0] d,
      input int nw, input int nr, input logic [3:0] exp);
    logic [3:0] k;
    logic [7:0] q;
    logic u;
    k = 4'h0;
    rdata = 16'h0000;
    u_host.cond(1'b1, 1'b0);
    u_host.xbyte(dev, 1'b1, q, k[0]);
    u_host.xbyte(a, 1'b1, q, k[1]);
    for (int i = 0; i < nw; i++) begin
      u_host.xbyte(d[15 - 8 * i -: 8], 1'b1, q, k[2 + i]);
    end
    if (nr > 0) begin
      u_host.cond(1'b1, 1'b0);
      u_host.xbyte(8'h43, 1'b1, q, k[2]);
      for (int i = 0; i < nr; i++) begin
        u_host.xbyte(8'hFF, i == nr - 1, rdata[15 - 8 * i -: 8], u);
      end
    end
    u_host.cond(1'b0, 1'b1);
    check(k, exp);
  endtask
  initial begin
    reset = 1'b1;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    check(cfg, TSCP_REG_INIT);
    wait_mode(4'h1);
    check(fuse_cfg, {1'b1, FUSE_DATA[62:0]});
    u_host.set_din(1'b1);
    wait_mode(4'h2);
    u_host.set_din(1'b0);
    wait_mode(4'h4);
    u_host.step(150);
    check(modes, 4'h4);
    // Fuse copy set a shorter delay field, so that instance is asleep already
    check({fuse_modes, fuse_pa, fuse_oe, fuse_out, sda_out}, {4'h1, 4'h0, 3'h0});
    wait_mode(4'h1);
    u_host.scl_low(200);
    check(modes, 4'h8);
    frame(8'h42, 8'h01, 16'hF100, 1, 0, 4'h0);
    frame(8'h42, 8'h02, 16'h5AC3, 2, 0, 4'h0);
    frame(8'h42, 8'h07, 16'hCB00, 1, 0, 4'h0);
    frame(8'h42, 8'h08, 16'h7700, 1, 0, 4'h4);
    frame(8'h44, 8'h00, 16'h1100, 1, 0, 4'h7);
    check(cfg, 64'h4B3D7059C35AF1A0);
    frame(8'h42, 8'h02, 16'h0000, 0, 2, 4'h0);
    check(rdata, 16'h5AC3);
    frame(8'h42, 8'h07, 16'h0000, 0, 1, 4'h0);
    check(rdata, 16'h4B00);
    u_host.scl_low(200);
    check(modes, 4'h1);
    u_host.set_din(1'b1);
    wait_mode(4'h2);
    u_host.step(200);
    check(pa, TSCP_PA_MAX);
    u_host.set_din(1'b0);
    wait_mode(4'h4);
    u_host.step(300);
    check(modes, 4'h4);
    u_host.set_din(1'b1);
    wait_mode(4'h2);
    u_host.set_din(1'b0);
    reset = 1'b1;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    check(cfg, TSCP_REG_INIT);
    wrap_up();
  end
  // The sequence needs about 6000 cycles; this limit leaves ample margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
endmodule // tscp_top_tb
`default_nettype wire
